// file: verilog/iao_pkg.sv
// package: operation codes, sizes, flag layout and operand widths for the integer alu slice
package iao_pkg;
    localparam int IAO_DATA_W   = 32;
    localparam int IAO_BYTE_W   = 8;
    localparam int IAO_WORD_W   = 16;
    localparam int IAO_DIV_CYC  = 1;
    localparam logic [3:0] IAO_RST_FLAGS = 4'h0;
    localparam int IAO_FLAG_N = 3;
    localparam int IAO_FLAG_Z = 2;
    localparam int IAO_FLAG_V = 1;
    localparam int IAO_FLAG_C = 0;
    localparam logic [7:0] IAO_TAS_SET = 8'h80;

    typedef enum logic [2:0] {
        IAO_OP_DIV  = 3'h0,
        IAO_OP_CMP  = 3'h1,
        IAO_OP_NEG  = 3'h2,
        IAO_OP_ZERO_EXTEND_OP = 3'h3,
        IAO_OP_SIGN_EXTEND_OP = 3'h4,
        IAO_OP_TAS  = 3'h5
    } iao_op_t;

    typedef enum logic [1:0] {
        IAO_SZ_B = 2'h0,
        IAO_SZ_W = 2'h1,
        IAO_SZ_L = 2'h2
    } iao_size_t;

    typedef struct packed {
        iao_op_t    op;
        iao_size_t  size;
        logic       use_imm;
        logic [31:0] dst;
        logic [31:0] src;
        logic [31:0] imm;
    } iao_req_t;

    typedef struct packed {
        logic        wr_dst;
        logic [31:0] result;
        logic [3:0]  flags;
        logic        flags_upd;
        logic        div_zero;
    } iao_rsp_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [31:0] addr;
        logic [7:0]  wdata;
    } iao_mem_t;
endpackage

// file: verilog/iao_alu.sv
// integer alu slice: signed divide, compare, negate, extends and test-and-set
`timescale 1ns/10ps
//
// How it works
// - signed divide takes 16/8 or 32/16 and writes remainder high, quotient low into the destination.
// - compare subtracts source or immediate from destination at byte, word or long width and keeps no result.
// - compare only updates flags and never writes back an operand.
// - negate writes zero minus the destination at byte, word or long width.
// - zero extend widens the low byte to a word or the low word to a long with zeros above.
// - sign extend widens the same way but copies the top bit of the source part upward.
// - test-and-set reads a byte at the register address, flags it against zero, writes it back with bit 7 set.
module iao_alu (
    input  wire logic                clock,
    input  wire logic                arst_n,
    input  wire logic                req_valid,
    input  wire iao_pkg::iao_req_t   req,
    input  wire logic                mem_ack,
    input  wire logic [7:0]          mem_rdata,
    output iao_pkg::iao_rsp_t        rsp,
    output logic                     rsp_valid,
    output logic                     busy,
    output iao_pkg::iao_mem_t        mem,
    output logic [3:0]               condition_code_register
);
    import iao_pkg::*;

    typedef enum logic [1:0] {
        IAO_ST_IDLE  = 2'b00,
        IAO_ST_READ  = 2'b01,
        IAO_ST_WRITE = 2'b11
    } iao_state_t;

    iao_state_t  state_r;
    iao_rsp_t    alu_nxt;
    logic [31:0] opb;
    logic [32:0] diff;
    logic        neg_a;
    logic        neg_b;
    logic        ovf;
    logic [31:0] a_mag;
    logic [31:0] b_mag;
    logic [31:0] q_mag;
    logic [31:0] r_mag;
    logic [15:0] q_s;
    logic [15:0] r_s;
    logic [7:0]  tas_byte_r;

    ////////////////////////////////////////////////////////////////////////
    // combinational datapath for the single-cycle operations
    always_comb begin
        alu_nxt = '0;
        opb   = req.use_imm ? req.imm : req.src;
        diff  = '0;
        neg_a = 1'b0;
        neg_b = 1'b0;
        ovf   = 1'b0;
        a_mag = '0;
        b_mag = '0;
        q_mag = '0;
        r_mag = '0;
        q_s   = '0;
        r_s   = '0;
        unique case (req.op)
            IAO_OP_CMP, IAO_OP_NEG: begin
                // compare and negate share one subtractor; negate is 0 - rd
                if (req.op == IAO_OP_NEG) begin
                    diff = {1'b0, 32'h0} - {1'b0, req.dst};
                end else begin
                    diff = {1'b0, req.dst} - {1'b0, opb};
                end
                unique case (req.size)
                    IAO_SZ_B: begin
                        alu_nxt.result = {24'h0, diff[7:0]};
                        alu_nxt.flags[IAO_FLAG_N] = diff[7];
                        alu_nxt.flags[IAO_FLAG_Z] = (diff[7:0] == 8'h00);
                        alu_nxt.flags[IAO_FLAG_C] = (req.op == IAO_OP_NEG) ? (req.dst[7:0] != 8'h00)
                                                                          : (req.dst[7:0] < opb[7:0]);
                        ovf = (req.op == IAO_OP_NEG) ? (req.dst[7:0] == 8'h80)
                                                     : ((req.dst[7] ^ opb[7]) & (req.dst[7] ^ diff[7]));
                        alu_nxt.result = {req.dst[31:8], diff[7:0]};
                    end
                    IAO_SZ_W: begin
                        alu_nxt.flags[IAO_FLAG_N] = diff[15];
                        alu_nxt.flags[IAO_FLAG_Z] = (diff[15:0] == 16'h0000);
                        alu_nxt.flags[IAO_FLAG_C] = (req.op == IAO_OP_NEG) ? (req.dst[15:0] != 16'h0000)
                                                                          : (req.dst[15:0] < opb[15:0]);
                        ovf = (req.op == IAO_OP_NEG) ? (req.dst[15:0] == 16'h8000)
                                                     : ((req.dst[15] ^ opb[15]) & (req.dst[15] ^ diff[15]));
                        alu_nxt.result = {req.dst[31:16], diff[15:0]};
                    end
                    default: begin
                        alu_nxt.flags[IAO_FLAG_N] = diff[31];
                        alu_nxt.flags[IAO_FLAG_Z] = (diff[31:0] == 32'h0);
                        alu_nxt.flags[IAO_FLAG_C] = (req.op == IAO_OP_NEG) ? (req.dst != 32'h0) : diff[32];
                        ovf = (req.op == IAO_OP_NEG) ? (req.dst == 32'h8000_0000)
                                                     : ((req.dst[31] ^ opb[31]) & (req.dst[31] ^ diff[31]));
                        alu_nxt.result = diff[31:0];
                    end
                endcase
                alu_nxt.flags[IAO_FLAG_V] = ovf;
                alu_nxt.flags_upd = 1'b1;
                alu_nxt.wr_dst    = (req.op == IAO_OP_NEG); // compare never writes back
            end
            IAO_OP_ZERO_EXTEND_OP, IAO_OP_SIGN_EXTEND_OP: begin
                // word size takes the low byte, long size the low word
                if (req.size == IAO_SZ_W) begin
                    neg_a = (req.op == IAO_OP_SIGN_EXTEND_OP) & req.dst[7];
                    alu_nxt.result = {req.dst[31:16], {8{neg_a}}, req.dst[7:0]};
                    alu_nxt.flags[IAO_FLAG_N] = alu_nxt.result[15];
                    alu_nxt.flags[IAO_FLAG_Z] = (alu_nxt.result[15:0] == 16'h0000);
                end else begin
                    neg_a = (req.op == IAO_OP_SIGN_EXTEND_OP) & req.dst[15];
                    alu_nxt.result = {{16{neg_a}}, req.dst[15:0]};
                    alu_nxt.flags[IAO_FLAG_N] = alu_nxt.result[31];
                    alu_nxt.flags[IAO_FLAG_Z] = (alu_nxt.result == 32'h0);
                end
                alu_nxt.wr_dst    = 1'b1;
                alu_nxt.flags_upd = 1'b1; // v and c clear
            end
            IAO_OP_DIV: begin
                // sign-magnitude divide; limitation: a single-cycle combinational divider
                if (req.size == IAO_SZ_B) begin
                    neg_a = req.dst[15];
                    neg_b = req.src[7];
                    a_mag = {16'h0, neg_a ? 16'(-req.dst[15:0]) : req.dst[15:0]};
                    b_mag = {24'h0, neg_b ? 8'(-req.src[7:0]) : req.src[7:0]};
                end else begin
                    neg_a = req.dst[31];
                    neg_b = req.src[15];
                    a_mag = neg_a ? 32'(-req.dst) : req.dst;
                    b_mag = {16'h0, neg_b ? 16'(-req.src[15:0]) : req.src[15:0]};
                end
                alu_nxt.div_zero = (b_mag == 32'h0);
                if (!alu_nxt.div_zero) begin
                    q_mag = a_mag / b_mag;
                    r_mag = a_mag % b_mag;
                end
                q_s = (neg_a ^ neg_b) ? 16'(-q_mag[15:0]) : q_mag[15:0];
                r_s = neg_a ? 16'(-r_mag[15:0]) : r_mag[15:0];
                if (req.size == IAO_SZ_B) begin
                    alu_nxt.result = {req.dst[31:16], r_s[7:0], q_s[7:0]};
                    alu_nxt.flags[IAO_FLAG_N] = q_s[7];
                    alu_nxt.flags[IAO_FLAG_Z] = (b_mag[7:0] == 8'h00);
                end else begin
                    alu_nxt.result = {r_s, q_s};
                    alu_nxt.flags[IAO_FLAG_N] = q_s[15];
                    alu_nxt.flags[IAO_FLAG_Z] = (b_mag[15:0] == 16'h0000);
                end
                alu_nxt.wr_dst    = !alu_nxt.div_zero;
                alu_nxt.flags_upd = 1'b1;
            end
            default: begin
                alu_nxt = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: test-and-set needs a memory read and a write
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= IAO_ST_IDLE;
        end else begin
            unique case (state_r)
                IAO_ST_IDLE: begin
                    if (req_valid && req.op == IAO_OP_TAS) begin
                        state_r <= IAO_ST_READ;
                    end
                end
                IAO_ST_READ: begin
                    if (mem_ack) begin
                        state_r <= IAO_ST_WRITE;
                    end
                end
                IAO_ST_WRITE: begin
                    if (mem_ack) begin
                        state_r <= IAO_ST_IDLE;
                    end
                end
                default: begin
                    state_r <= IAO_ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tas_byte_r <= 8'h00;
        end else if (state_r == IAO_ST_READ && mem_ack) begin
            tas_byte_r <= mem_rdata;
        end
    end

    // memory strobes held until ack
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            mem <= '0;
        end else begin
            mem.rd <= (state_r == IAO_ST_IDLE && req_valid && req.op == IAO_OP_TAS)
                      || (state_r == IAO_ST_READ && !mem_ack);
            mem.wr <= (state_r == IAO_ST_READ && mem_ack) || (state_r == IAO_ST_WRITE && !mem_ack);
            if (state_r == IAO_ST_IDLE && req_valid) begin
                mem.addr <= req.dst;
            end
            if (state_r == IAO_ST_READ && mem_ack) begin
                mem.wdata <= mem_rdata | IAO_TAS_SET;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // answer and condition code register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rsp       <= '0;
            rsp_valid <= 1'b0;
            condition_code_register       <= IAO_RST_FLAGS;
        end else begin
            rsp_valid <= 1'b0;
            if (state_r == IAO_ST_IDLE && req_valid && req.op != IAO_OP_TAS) begin
                rsp       <= alu_nxt;
                rsp_valid <= 1'b1;
                condition_code_register       <= alu_nxt.flags;
            end else if (state_r == IAO_ST_WRITE && mem_ack) begin
                rsp           <= '0;
                rsp.flags_upd <= 1'b1;
                rsp.flags     <= {tas_byte_r[7], tas_byte_r == 8'h00, 2'b00};
                rsp_valid     <= 1'b1;
                condition_code_register           <= {tas_byte_r[7], tas_byte_r == 8'h00, 2'b00};
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_r == IAO_ST_IDLE) ? (req_valid && req.op == IAO_OP_TAS)
                                             : !(state_r == IAO_ST_WRITE && mem_ack);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_cmp_no_write: assert property (@(posedge clock) disable iff (!arst_n)
        (state_r == IAO_ST_IDLE && req_valid && req.op == IAO_OP_CMP) |=> (rsp_valid && !rsp.wr_dst))
        else $error("compare wrote back");
    chk_cmp_zero_flag: assert property (@(posedge clock) disable iff (!arst_n)
        (state_r == IAO_ST_IDLE && req_valid && req.op == IAO_OP_CMP && !req.use_imm
         && req.size == IAO_SZ_L && req.dst == req.src) |=> condition_code_register[IAO_FLAG_Z] && !condition_code_register[IAO_FLAG_C])
        else $error("equal compare not zero");
    chk_neg_value: assert property (@(posedge clock) disable iff (!arst_n)
        (state_r == IAO_ST_IDLE && req_valid && req.op == IAO_OP_NEG && req.size == IAO_SZ_L)
        |=> rsp.wr_dst && rsp.result == 32'h0 - $past(req.dst))
        else $error("negate wrong");
    chk_zero_extend_op_fill: assert property (@(posedge clock) disable iff (!arst_n)
        (state_r == IAO_ST_IDLE && req_valid && req.op == IAO_OP_ZERO_EXTEND_OP && req.size == IAO_SZ_L)
        |=> rsp.result[31:16] == 16'h0000)
        else $error("zero extend upper bits");
    chk_sign_extend_op_fill: assert property (@(posedge clock) disable iff (!arst_n)
        (state_r == IAO_ST_IDLE && req_valid && req.op == IAO_OP_SIGN_EXTEND_OP && req.size == IAO_SZ_L)
        |=> rsp.result[31:16] == {16{$past(req.dst[15])}})
        else $error("sign extend upper bits");
    chk_div_recombine: assert property (@(posedge clock) disable iff (!arst_n)
        (state_r == IAO_ST_IDLE && req_valid && req.op == IAO_OP_DIV && req.size == IAO_SZ_W
         && req.src[15:0] != 16'h0 && !req.dst[31] && !req.src[15] && req.dst[31:16] < req.src[15:0])
        |=> rsp.wr_dst && (32'(rsp.result[15:0]) * 32'($past(req.src[15:0])) + 32'(rsp.result[31:16])
                           == $past(req.dst)))
        else $error("divide mismatch");
    chk_tas_bit7: assert property (@(posedge clock) disable iff (!arst_n)
        (state_r == IAO_ST_READ && mem_ack) |=> mem.wr && mem.wdata[7])
        else $error("tas write lacks bit 7");
    chk_tas_done: assert property (@(posedge clock) disable iff (!arst_n)
        (state_r == IAO_ST_WRITE && mem_ack) |=> rsp_valid && condition_code_register[IAO_FLAG_Z] == (tas_byte_r == 8'h00))
        else $error("tas flags wrong");
    chk_ext_vc_clear: assert property (@(posedge clock) disable iff (!arst_n)
        (state_r == IAO_ST_IDLE && req_valid && (req.op == IAO_OP_ZERO_EXTEND_OP || req.op == IAO_OP_SIGN_EXTEND_OP))
        |=> condition_code_register[1:0] == 2'b00)
        else $error("extend left v or c set");

    cov_cmp:  cover property (@(posedge clock) rsp_valid && !rsp.wr_dst && rsp.flags_upd);
    cov_div:  cover property (@(posedge clock) state_r == IAO_ST_IDLE && req_valid && req.op == IAO_OP_DIV);
    cov_tas:  cover property (@(posedge clock) state_r == IAO_ST_WRITE && mem_ack);
    cov_negv: cover property (@(posedge clock) rsp_valid && condition_code_register[IAO_FLAG_V]);
endmodule

// file: verification/integer_alu_ops_tb.sv
// self-checking bench for the integer alu slice: reference model, directed and random operations
`timescale 1ns/10ps
module integer_alu_ops_tb;
    import iao_pkg::*;
    typedef struct packed {
        logic [31:0] res;
        logic [31:0] msk;
        logic        wr;
        logic        ckw;
        logic [3:0]  fl;
        logic [3:0]  flm;
        logic        dz;
    } iao_exp_t;
    logic       clock;
    logic       arst_n;
    logic       req_valid;
    iao_req_t   req;
    logic       mem_ack;
    logic [7:0] mem_rdata;
    iao_rsp_t   rsp;
    logic       rsp_valid;
    logic       busy;
    iao_mem_t   mem;
    logic [3:0] condition_code_register;
    int         n_mismatch = 0;
    int         num_checks = 0;
    int         seed       = 70;
    iao_exp_t   exp_q[$];
    iao_exp_t   mon_e;
    iao_alu dut_u (.clock(clock), .arst_n(arst_n), .req_valid(req_valid), .req(req), .mem_ack(mem_ack),
                   .mem_rdata(mem_rdata), .rsp(rsp), .rsp_valid(rsp_valid), .busy(busy), .mem(mem), .condition_code_register(condition_code_register));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // reference model; test-and-set carries the byte the bench will return in src
    function automatic iao_exp_t model(input iao_req_t q);
        iao_exp_t e;
        int w, h;
        logic [31:0] m, hm, d, b, r;
        longint dv, dr, qt, rm;
        e = '0;
        w = (q.size == IAO_SZ_B) ? 8 : (q.size == IAO_SZ_W) ? 16 : 32;
        m = (w == 32) ? 32'hffffffff : ((32'h1 << w) - 32'h1);
        h = w / 2;
        hm = (32'h1 << h) - 32'h1;
        d = q.dst & m;
        b = (q.use_imm ? q.imm : q.src) & m;
        e.msk = m;
        e.wr = 1'b1;
        e.ckw = 1'b1;
        e.flm = 4'hf;
        r = 32'h0;
        case (q.op)
            IAO_OP_CMP: begin
                r = (d - b) & m;
                e.wr = 1'b0;
                e.msk = 32'h0;
                e.fl[1] = (d[w-1] != b[w-1]) && (r[w-1] != d[w-1]);
                e.fl[0] = b > d;
            end
            IAO_OP_NEG: begin
                r = (32'h0 - d) & m;
                e.res = (q.dst & ~m) | r;
                e.msk = 32'hffffffff;
                e.fl[1] = d == (m ^ (m >> 1));
                e.fl[0] = d != 32'h0;
            end
            IAO_OP_ZERO_EXTEND_OP, IAO_OP_SIGN_EXTEND_OP: begin
                r = q.dst & hm;
                if (q.op == IAO_OP_SIGN_EXTEND_OP && r[h-1])
                    r = r | (m & ~hm);
                e.res = r;
            end
            IAO_OP_TAS: begin
                e.ckw = 1'b0;
                e.msk = 32'h0;
                e.fl = {q.src[7], q.src[7:0] == 8'h00, 2'b00};
            end
            default: begin
                // divide: at byte and word size w is the divisor width, the dividend is twice that
                dv = (q.size == IAO_SZ_B) ? longint'($signed(q.dst[15:0])) : longint'($signed(q.dst));
                dr = (q.size == IAO_SZ_B) ? longint'($signed(q.src[7:0])) : longint'($signed(q.src[15:0]));
                if (dr == 0) begin
                    e.wr = 1'b0;
                    e.dz = 1'b1;
                    e.msk = 32'h0;
                    e.fl = 4'h4;
                    e.flm = 4'h4;
                end else begin
                    qt = dv / dr;
                    rm = dv % dr;
                    e.res = (q.size == IAO_SZ_B) ? {q.dst[31:16], rm[7:0], qt[7:0]} : {rm[15:0], qt[15:0]};
                    e.msk = 32'hffffffff;
                    e.fl = {((q.size == IAO_SZ_B) ? qt[7] : qt[15]), 3'b000};
                end
            end
        endcase
        if (q.op inside {IAO_OP_CMP, IAO_OP_NEG, IAO_OP_ZERO_EXTEND_OP, IAO_OP_SIGN_EXTEND_OP}) begin
            e.fl[3] = r[w-1];
            e.fl[2] = r == 32'h0;
        end
        return e;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // every answer is compared with the oldest outstanding expectation
    always @(posedge clock) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                mon_e = exp_q.pop_front();
                chk(rsp.result & mon_e.msk, mon_e.res & mon_e.msk);
                if (mon_e.ckw)
                    chk(32'(rsp.wr_dst), 32'(mon_e.wr));
                chk(32'(rsp.flags & mon_e.flm), 32'(mon_e.fl & mon_e.flm));
                chk(32'(condition_code_register & mon_e.flm), 32'(mon_e.fl & mon_e.flm));
                chk(32'(rsp.div_zero), 32'(mon_e.dz));
                chk(32'(rsp.flags_upd), 32'h1);
            end
        end
    end
    task automatic issue(input iao_req_t q, input bit push);
        @(posedge clock);
        req_valid <= 1'b1;
        req <= q;
        if (push)
            exp_q.push_back(model(q));
    endtask
    task automatic go(input iao_op_t op, input iao_size_t sz, input logic ui, input logic [31:0] d,
                      input logic [31:0] s, input logic [31:0] im);
        iao_req_t q;
        q = '{op: op, size: sz, use_imm: ui, dst: d, src: s, imm: im};
        issue(q, 1'b1);
    endtask
    task automatic idle(input int n);
        @(posedge clock);
        req_valid <= 1'b0;
        repeat (n) @(posedge clock);
    endtask
    task automatic wait_mem(input bit wr_phase);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while ((wr_phase ? mem.wr : mem.rd) !== 1'b1 && n < 20);
        chk(32'(n < 20), 32'h1);
    endtask
    task automatic ack(input int dly, input logic [7:0] v);
        repeat (dly) @(posedge clock);
        @(posedge clock);
        mem_ack <= 1'b1;
        mem_rdata <= v;
        @(posedge clock);
        mem_ack <= 1'b0;
        mem_rdata <= ~v;
    endtask
    // test-and-set with a compare thrown in while busy, which must be ignored
    task automatic test_and_set_op(input logic [31:0] a, input logic [7:0] v, input int dly);
        go(IAO_OP_TAS, IAO_SZ_B, 1'b0, a, {24'h0, v}, 32'h0);
        idle(0);
        wait_mem(1'b0);
        chk(mem.addr, a);
        chk(32'(busy), 32'h1);
        ack(dly, v);
        wait_mem(1'b1);
        chk(32'(mem.rd), 32'h0);
        chk(32'(mem.wdata), 32'(v | IAO_TAS_SET));
        issue('{op: IAO_OP_CMP, size: IAO_SZ_L, use_imm: 1'b0, dst: 32'h5, src: 32'h1, imm: 32'h0}, 1'b0);
        idle(0);
        ack(dly, 8'h00);
        repeat (3) @(posedge clock);
        #1;
        chk(32'(busy), 32'h0);
        chk(32'(mem.wr), 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
    initial begin
        iao_req_t q;
        int k;
        arst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        mem_ack = 1'b0;
        mem_rdata = 8'h00;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        #1;
        chk(32'(condition_code_register), 32'(IAO_RST_FLAGS));
        chk(32'({rsp_valid, busy, mem.rd, mem.wr}), 32'h0);
        // directed boundaries, issued back to back
        go(IAO_OP_DIV, IAO_SZ_B, 1'b0, 32'h1234ff9c, 32'h7, 32'h0);
        go(IAO_OP_DIV, IAO_SZ_W, 1'b0, 32'hfffe7961, 32'hffc8, 32'h0);
        go(IAO_OP_DIV, IAO_SZ_B, 1'b0, 32'h00000064, 32'h100, 32'h0);
        go(IAO_OP_DIV, IAO_SZ_W, 1'b0, 32'h00000064, 32'h0, 32'h0);
        go(IAO_OP_CMP, IAO_SZ_L, 1'b1, 32'h80000000, 32'h0, 32'h1);
        go(IAO_OP_CMP, IAO_SZ_B, 1'b0, 32'hffffff10, 32'h11, 32'h0);
        go(IAO_OP_CMP, IAO_SZ_W, 1'b1, 32'h00001234, 32'h0, 32'h1234);
        go(IAO_OP_CMP, IAO_SZ_L, 1'b0, 32'h89abcdef, 32'h89abcdef, 32'h0);
        go(IAO_OP_NEG, IAO_SZ_B, 1'b0, 32'habcd0080, 32'h0, 32'h0);
        go(IAO_OP_NEG, IAO_SZ_W, 1'b0, 32'h55550000, 32'h0, 32'h0);
        go(IAO_OP_NEG, IAO_SZ_L, 1'b0, 32'h00000001, 32'h0, 32'h0);
        go(IAO_OP_ZERO_EXTEND_OP, IAO_SZ_L, 1'b0, 32'hffff8000, 32'h0, 32'h0);
        go(IAO_OP_ZERO_EXTEND_OP, IAO_SZ_W, 1'b0, 32'h0000ff00, 32'h0, 32'h0);
        go(IAO_OP_SIGN_EXTEND_OP, IAO_SZ_W, 1'b0, 32'h00000080, 32'h0, 32'h0);
        go(IAO_OP_SIGN_EXTEND_OP, IAO_SZ_L, 1'b0, 32'h12347fff, 32'h0, 32'h0);
        idle(3);
        test_and_set_op(32'h0000ff80, 8'h00, 0);
        test_and_set_op(32'h00001001, 8'h5a, 3);
        test_and_set_op(32'hfffffffe, 8'h80, 1);
        // random mix of every operation except test-and-set, at every size except long divide and byte extends, back to back
        for (int i = 0; i < 300; i++) begin
            k = ($random(seed) & 32'h7fffffff) % 15;
            q.op = iao_op_t'(3'(k % 5));
            q.size = iao_size_t'(2'(k / 5));
            q.use_imm = 1'($random(seed));
            q.dst = $random(seed);
            q.src = ((k & 3) == 0) ? q.dst : 32'($random(seed));
            q.imm = ((k & 3) == 1) ? q.dst : 32'($random(seed));
            if (q.op == IAO_OP_DIV && q.size == IAO_SZ_L)
                q.size = IAO_SZ_W;
            if (q.op inside {IAO_OP_ZERO_EXTEND_OP, IAO_OP_SIGN_EXTEND_OP} && q.size == IAO_SZ_B)
                q.size = IAO_SZ_L;
            // keep the quotient inside its field so that no overflow arises
            if (q.op == IAO_OP_DIV && q.size == IAO_SZ_B)
                q.dst[15:0] = {{9{q.dst[6]}}, q.dst[6:0]};
            if (q.op == IAO_OP_DIV && q.size == IAO_SZ_W)
                q.dst = {{17{q.dst[14]}}, q.dst[14:0]};
            issue(q, 1'b1);
        end
        idle(4);
        chk(32'(exp_q.size()), 32'h0);
        conclude();
    end
endmodule
